// File: common/agc_pkg.sv
package agc_pkg;

    // Wishbone register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_MANUAL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_COUNTS = 8'h0c;

    // Control register field positions
    localparam int CTRL_REF_LSB    = 0;
    localparam int CTRL_FAST_BIT   = 3;
    localparam int CTRL_OVL_LSB    = 4;
    localparam int CTRL_DGEN_BIT   = 7;
    localparam int CTRL_DECAY_LSB  = 8;
    localparam int CTRL_ATTACK_LSB = 12;
    localparam int CTRL_FRAME_BIT  = 16;

    // Reset values
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [15:0] MANUAL_RESET = 16'h0000;

    // Loop rate: one update per sixty modulator clocks
    localparam int          LOOP_DIV  = 60;
    localparam logic [5:0]  DIV_LAST  = 6'(LOOP_DIV - 1);

    // Attenuation code space: low half is digital gain, high half analog
    localparam logic [15:0] ATT_HALF = 16'h8000;
    localparam logic [15:0] ATT_MAX  = 16'hffff;

    // Level scale: full scale of |I|+|Q| on 16-bit samples is 32768
    localparam logic [16:0] CLIP_LEVEL = 17'h065ad;   // Full scale less 2 dB
    localparam logic [16:0] REF_3DB    = 17'h047fb;
    localparam logic [16:0] REF_6DB    = 17'h032f5;
    localparam logic [16:0] REF_9DB    = 17'h02413;
    localparam logic [16:0] REF_12DB   = 17'h0198a;
    localparam logic [16:0] REF_15DB   = 17'h01215;

    // Loop gain: right shift in half-octave steps at attack code zero
    localparam logic [5:0]  LOOP_H0  = 6'd30;
    localparam logic [5:0]  ENV_H0   = 6'd2;
    localparam logic [5:0]  H_MAX    = 6'd40;

    // Converter reset weighting: base step before doubling per code
    localparam logic [15:0] OVL_BASE = 16'h0001;

endpackage

// File: rtl/agc_loop.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Reference codes 1..7 enable the loop; 1..5 target 3 to 15 dB below clip, 6 and 7 target the clip level.
// - Reference code zero disables the loop; gain follows the manual register.
// - Gain and the envelope update once every sixty clocks; peak and reset sum gather every clock.
// - Clip level sits 2 dB below converter full scale.
// - Level estimate is |I|+|Q| after first decimator and after digital gain.
// - Digital gain off: only the analog stage, driven by the first-decimator estimate.
// - Estimate above reference raises attenuation, step scaled by attack code.
// - Estimate below reference lowers attenuation, step scaled by attack minus decay.
// - Attack code sets bandwidth; each step is a factor of root two.
// - Decay code slows estimator decay by root two per step.
// - Overload weight sets attenuation per converter reset, doubling per step.
// - Reset-driven ramp spans 12 dB quickly at high weight, slowly at low.
// - Fast-acquire bit lowers gain DAC source resistance.
// - Digital gain on: loop uses the larger of both estimates.
// - Digital gain 1..4; at 4 drop two top bits, keep next sixteen.
// - Digital gain falls to 1 first; beyond that the analog stage attenuates.
// - Digital gain kept maximal without post-gain estimate exceeding reference.
// - Frame carries per-sample overload and reset counts and gain top byte.
// - Within range the loop settles where estimate equals the reference.
// - Digital gain stage works only when enabled; otherwise fixed unity.
module agc_loop #(
    parameter int DW = 24,
    parameter int OW = 16
) (
    input  wire logic                 CLOCK,
    input  wire logic                 RST_N,
    input  wire logic                 CE,
    input  wire logic                 WB_CYC_I,
    input  wire logic                 WB_STB_I,
    input  wire logic                 WB_WE_I,
    input  wire logic [7:0]           WB_ADR_I,
    input  wire logic [3:0]           WB_SEL_I,
    input  wire logic [31:0]          WB_DAT_I,
    output logic      [31:0]          WB_DAT_O,
    output logic                      WB_ACK_O,
    input  wire logic signed [DW-1:0] FIRST_DECIMATOR_I,
    input  wire logic signed [DW-1:0] FIRST_DECIMATOR_Q,
    input  wire logic                 FIRST_DECIMATOR_VALID,
    input  wire logic signed [DW-1:0] THIRD_DECIMATOR_I,
    input  wire logic signed [DW-1:0] THIRD_DECIMATOR_Q,
    input  wire logic                 THIRD_DECIMATOR_VALID,
    input  wire logic                 ADC_RESET_EVT,
    input  wire logic                 ADC_OVERLOAD_EVT,
    input  wire logic                 OUT_SAMPLE_STROBE,
    output logic      [7:0]           VGA_DAC_CODE,
    output logic                      FAST_ACQUIRE,
    output logic      [OW-1:0]        OUT_I,
    output logic      [OW-1:0]        OUT_Q,
    output logic                      OUT_VALID,
    output logic      [7:0]           FRAME_OVL_CNT,
    output logic      [7:0]           FRAME_RST_CNT,
    output logic      [7:0]           FRAME_GAIN_MSB
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Absolute value of the top sixteen bits of a sample
    function automatic logic [15:0] mag16(input logic signed [DW-1:0] x);
        logic signed [15:0] t;
        t = x[DW-1 -: 16];
        mag16 = t[15] ? 16'(-t) : 16'(t);
    endfunction

    // Scale by 2^(-h/2); odd h takes an extra factor of about 0.703
    function automatic logic [16:0] scale_h(input logic [16:0] e, input logic [5:0] h);
        logic [16:0] s;
        s = e >> h[5:1];
        scale_h = h[0] ? 17'((s >> 1) + (s >> 3) + (s >> 4) + (s >> 6)) : s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave and registers

    logic [31:0] ctrl_q;
    logic [15:0] manual_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic [15:0] att_q;
    logic [16:0] env1_q;
    logic [16:0] est2_q;
    logic [7:0]  frm_ovl_q;
    logic [7:0]  frm_rst_q;

    wire         wb_req   = WB_CYC_I && WB_STB_I;
    wire         wb_take  = wb_req && !ack_q;
    wire         wb_wr    = wb_req && ack_q && WB_WE_I;  // Write lands on the ack edge
    wire         sel_ctrl = WB_ADR_I == agc_pkg::REG_CTRL;
    wire         sel_man  = WB_ADR_I == agc_pkg::REG_MANUAL;
    wire [31:0]  wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    wire [2:0]   ref_sel  = ctrl_q[agc_pkg::CTRL_REF_LSB +: 3];
    wire         fast_acq = ctrl_q[agc_pkg::CTRL_FAST_BIT];
    wire [2:0]   ovl_wt   = ctrl_q[agc_pkg::CTRL_OVL_LSB +: 3];
    wire         dg_en    = ctrl_q[agc_pkg::CTRL_DGEN_BIT];
    wire [3:0]   decay    = ctrl_q[agc_pkg::CTRL_DECAY_LSB +: 4];
    wire [3:0]   attack   = ctrl_q[agc_pkg::CTRL_ATTACK_LSB +: 4];
    wire         frame_en = ctrl_q[agc_pkg::CTRL_FRAME_BIT];

    // Read mux; unmapped offsets answer zero
    wire [31:0]  rd_mux =
        (WB_ADR_I == agc_pkg::REG_CTRL)   ? {15'h0000, ctrl_q[16:0]} :
        (WB_ADR_I == agc_pkg::REG_MANUAL) ? {16'h0000, manual_q} :
        (WB_ADR_I == agc_pkg::REG_STATUS) ? {env1_q[16:1], att_q} :
        (WB_ADR_I == agc_pkg::REG_COUNTS) ? {16'h0000, frm_rst_q, frm_ovl_q} : 32'h0000_0000;

    // Ack one cycle after the request is taken, dropped the cycle after
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (CE) begin
            ack_q   <= wb_take;
            rdata_q <= wb_take ? rd_mux : rdata_q;
        end
    end

    // Writable registers with byte lanes
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q   <= agc_pkg::CTRL_RESET;
            manual_q <= agc_pkg::MANUAL_RESET;
        end else if (CE && wb_wr) begin
            if (sel_ctrl) ctrl_q <= ((ctrl_q & ~wmask) | (WB_DAT_I & wmask)) & 32'h0001_ffff;
            if (sel_man) manual_q <= (manual_q & ~wmask[15:0]) | (WB_DAT_I[15:0] & wmask[15:0]);
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Loop timebase

    logic [5:0] div_q;
    wire        tick = div_q == agc_pkg::DIV_LAST;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) div_q <= 6'h00;
        else if (CE) div_q <= tick ? 6'h00 : div_q + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Level estimation

    logic [16:0] peak1_q;
    logic [15:0] rst_acc_q;
    logic [1:0]  dg_sh_q;

    wire [16:0] x1     = 17'(mag16(FIRST_DECIMATOR_I)) + 17'(mag16(FIRST_DECIMATOR_Q));
    wire [16:0] x2     = 17'(mag16({OUT_I, {(DW-OW){1'b0}}})) + 17'(mag16({OUT_Q, {(DW-OW){1'b0}}}));
    wire [16:0] peak1_n = (FIRST_DECIMATOR_VALID && x1 > peak1_q) ? x1 : peak1_q;

    // Decay runs slower than attack by root two per decay step
    wire [16:0] env_up  = scale_h(peak1_q - env1_q, agc_pkg::ENV_H0);
    wire [16:0] env_dn  = scale_h(env1_q - peak1_q, agc_pkg::ENV_H0 + 6'(decay));
    wire [16:0] env1_d  = (peak1_q >= env1_q) ? env1_q + env_up : env1_q - env_dn;

    // Peak is held between ticks so short bursts still count
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            peak1_q <= 17'h00000;
            env1_q  <= 17'h00000;
            est2_q  <= 17'h00000;
        end else if (CE) begin
            peak1_q <= tick ? 17'h00000 : peak1_n;
            env1_q  <= tick ? env1_d : env1_q;
            est2_q  <= OUT_VALID ? x2 : est2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain loop

    // Target at or below the clip level, which is already 2 dB under full scale
    wire [16:0] ref_lvl =
        (ref_sel == 3'd1) ? agc_pkg::REF_3DB :
        (ref_sel == 3'd2) ? agc_pkg::REF_6DB :
        (ref_sel == 3'd3) ? agc_pkg::REF_9DB :
        (ref_sel == 3'd4) ? agc_pkg::REF_12DB :
        (ref_sel == 3'd5) ? agc_pkg::REF_15DB : agc_pkg::CLIP_LEVEL;
    wire        loop_on = ref_sel != 3'd0;

    // Larger estimate wins when the digital stage is in play
    wire [16:0] est     = (dg_en && est2_q > env1_q) ? est2_q : env1_q;
    wire        over    = est > ref_lvl;
    wire [16:0] err     = over ? est - ref_lvl : ref_lvl - est;

    // Half-octave shift counts; a decay above attack just slows further
    wire [5:0]  h_att   = agc_pkg::LOOP_H0 - 6'(attack);
    wire [5:0]  h_dec_r = h_att + 6'(decay);
    wire [5:0]  h_dec   = (h_dec_r > agc_pkg::H_MAX) ? agc_pkg::H_MAX : h_dec_r;
    wire [16:0] step_up = over ? scale_h(err, h_att) : 17'h00000;
    wire [16:0] step_dn = over ? 17'h00000 : scale_h(err, h_dec);

    // Converter resets gathered between ticks, weighted by doubling code
    wire [15:0] ovl_step = agc_pkg::OVL_BASE << ovl_wt;
    wire [15:0] rst_acc_n = (rst_acc_q > agc_pkg::ATT_MAX - ovl_step) ? agc_pkg::ATT_MAX : rst_acc_q + ovl_step;

    // Without the digital stage the floor is the analog half
    wire [15:0] att_min = dg_en ? 16'h0000 : agc_pkg::ATT_HALF;
    // A positive sum never reaches bit 18, so that bit flags a step below zero
    wire [18:0] att_sum = 19'(att_q) + 19'(step_up) + 19'(rst_acc_q) - 19'(step_dn);
    wire        att_neg = att_sum[18];
    wire [15:0] att_new =
        att_neg ? att_min :
        (att_sum > 19'(agc_pkg::ATT_MAX)) ? agc_pkg::ATT_MAX :
        (att_sum < 19'(att_min)) ? att_min : att_sum[15:0];

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            att_q     <= agc_pkg::ATT_HALF;
            rst_acc_q <= 16'h0000;
        end else if (CE) begin
            if (!loop_on) att_q <= manual_q;
            else if (tick) att_q <= att_new;
            if (tick) rst_acc_q <= ADC_RESET_EVT ? ovl_step : 16'h0000;  // Event on the tick opens next sum
            else if (ADC_RESET_EVT) rst_acc_q <= rst_acc_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gain split: digital gain spends itself before analog attenuation

    wire        in_dig   = att_q < agc_pkg::ATT_HALF;
    wire [1:0]  dg_sh_d  = (!dg_en || !in_dig) ? 2'd0 :
                           att_q[14] ? 2'd0 : (att_q[13] ? 2'd1 : 2'd2);
    wire [15:0] ana_att  = in_dig ? 16'h0000 : att_q - agc_pkg::ATT_HALF;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            dg_sh_q      <= 2'd0;
            VGA_DAC_CODE <= 8'h00;
            FAST_ACQUIRE <= 1'b0;
        end else if (CE) begin
            dg_sh_q      <= dg_sh_d;
            VGA_DAC_CODE <= ana_att[14:7];
            FAST_ACQUIRE <= fast_acq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital gain stage: a shift picks which sixteen bits leave

    wire [DW-1:0] sh_i = DW'(THIRD_DECIMATOR_I) << dg_sh_q;
    wire [DW-1:0] sh_q = DW'(THIRD_DECIMATOR_Q) << dg_sh_q;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_I     <= '0;
            OUT_Q     <= '0;
            OUT_VALID <= 1'b0;
        end else if (CE) begin
            OUT_VALID <= THIRD_DECIMATOR_VALID;
            if (THIRD_DECIMATOR_VALID) begin
                OUT_I <= sh_i[DW-1 -: OW];
                OUT_Q <= sh_q[DW-1 -: OW];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial frame fields; counts latched per output sample, gain byte taken live

    logic [7:0] ovl_cnt_q;
    logic [7:0] rst_cnt_q;
    wire  [7:0] ovl_inc = (ovl_cnt_q == 8'hff) ? ovl_cnt_q : ovl_cnt_q + 8'h01;
    wire  [7:0] rst_inc = (rst_cnt_q == 8'hff) ? rst_cnt_q : rst_cnt_q + 8'h01;

    // Counters saturate rather than wrap within one sample period
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ovl_cnt_q <= 8'h00;
            rst_cnt_q <= 8'h00;
            frm_ovl_q <= 8'h00;
            frm_rst_q <= 8'h00;
        end else if (CE) begin
            ovl_cnt_q <= OUT_SAMPLE_STROBE ? 8'(ADC_OVERLOAD_EVT) : (ADC_OVERLOAD_EVT ? ovl_inc : ovl_cnt_q);
            rst_cnt_q <= OUT_SAMPLE_STROBE ? 8'(ADC_RESET_EVT) : (ADC_RESET_EVT ? rst_inc : rst_cnt_q);
            if (OUT_SAMPLE_STROBE) begin
                frm_ovl_q <= ovl_cnt_q;
                frm_rst_q <= rst_cnt_q;
            end
        end
    end

    assign FRAME_OVL_CNT  = frame_en ? frm_ovl_q : 8'h00;
    assign FRAME_RST_CNT  = frame_en ? frm_rst_q : 8'h00;
    assign FRAME_GAIN_MSB = frame_en ? att_q[15:8] : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [6:0] since_tick_q;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) since_tick_q <= 7'd1;
        else if (CE) since_tick_q <= tick ? 7'd1 : since_tick_q + 7'd1;
    end

    sequence s_tick_loop;
        CE && tick && loop_on && !(wb_wr && sel_ctrl);
    endsequence

    sequence s_unity_two;
        (CE && !dg_en) ##1 (CE && !dg_en);
    endsequence

    chk_tick_spacing: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && tick) |-> since_tick_q == 7'd60)
        else $error("loop tick not sixty clocks apart");

    chk_att_holds_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && !tick && loop_on && !(wb_wr && sel_ctrl)) |=> $stable(att_q))
        else $error("attenuation moved between ticks");

    chk_manual_follow: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && !loop_on) |=> att_q == $past(manual_q))
        else $error("manual gain not applied");

    chk_attack_raises: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (s_tick_loop and (over && att_q >= att_min)) |=> att_q >= $past(att_q))
        else $error("attenuation fell while level above reference");

    chk_decay_lowers: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (s_tick_loop and (!over && rst_acc_q == 16'h0000 && att_q >= att_min)) |=> att_q <= $past(att_q))
        else $error("attenuation rose while level below reference");

    chk_floor_analog: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (s_tick_loop and !dg_en) |=> att_q >= agc_pkg::ATT_HALF)
        else $error("attenuation below analog floor");

    chk_unity_gain: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_unity_two |-> dg_sh_q == 2'd0)
        else $error("digital gain not unity while disabled");

    chk_out_slice: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && THIRD_DECIMATOR_VALID && dg_sh_q == 2'd2) |=> OUT_I == $past(THIRD_DECIMATOR_I[DW-3 -: OW]))
        else $error("gain four slice wrong");

    chk_frame_reset: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && OUT_SAMPLE_STROBE && frame_en && !(wb_wr && sel_ctrl)) |=> FRAME_RST_CNT == $past(rst_cnt_q))
        else $error("frame reset count not latched");

    chk_wb_answer: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (CE && wb_take) |=> WB_ACK_O ##1 (!WB_ACK_O || !CE))
        else $error("bus answer not one cycle");

endmodule // agc_loop

// File: sim/agc_far_end_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Far side: gain DAC with its RC node, and the framer that takes output words
module agc_far_end_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  dac_code,
    input  wire logic        fast_acquire,
    input  wire logic [15:0] out_i,
    input  wire logic [15:0] out_q,
    input  wire logic        out_valid,
    output logic      [15:0] cap_i,
    output logic      [15:0] cap_q,
    output logic      [31:0] cap_cnt,
    output logic      [15:0] gcp_level
);
    logic [15:0] gcp_q;
    logic [15:0] target;
    logic [3:0]  rc_shift;
    // Fast acquire lowers the source resistance, so the node moves faster
    assign target    = {dac_code, 8'h00};
    assign rc_shift  = fast_acquire ? 4'h1 : 4'h5;
    assign gcp_level = gcp_q;
    // RC node; the forced lsb stops it stalling up to 31 codes short of target
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gcp_q <= 16'h0000;
        end else if (gcp_q < target) begin
            gcp_q <= gcp_q + (((target - gcp_q) >> rc_shift) | 16'h0001);
        end else if (gcp_q > target) begin
            gcp_q <= gcp_q - (((gcp_q - target) >> rc_shift) | 16'h0001);
        end
    end
    // Framer latches each word offered with valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_i   <= 16'h0000;
            cap_q   <= 16'h0000;
            cap_cnt <= 32'h0;
        end else if (out_valid) begin
            cap_i   <= out_i;
            cap_q   <= out_q;
            cap_cnt <= cap_cnt + 32'h1;
        end
    end
endmodule // agc_far_end_model

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
    logic               clk, rst_n, cyc, stb, we, ack, d1_v, d3_v, rst_evt, ovl_evt, strobe, fast, o_v, ce;
    logic        [7:0]  adr, vga, f_ovl, f_rst, f_gain, vga_prev;
    logic        [3:0]  sel;
    logic        [31:0] wdat, rdat, rd, a0, cap_cnt, k;
    logic signed [23:0] d1_i, d1_q, d3_i, d3_q;
    logic        [15:0] o_i, o_q, cap_i, cap_q, gain_control_pin, inc0;
    logic        [23:0] t_i, t_q;
    logic               watch, seen;
    int                 n_errors, tests_run, gap, n;
    logic        [15:0] man_t[5] = '{16'h1000, 16'h3000, 16'h5000, 16'h9000, 16'h1000};
    int                 sh_t[5]  = '{2, 1, 0, 0, 0};

    agc_loop i_dut (.CLOCK(clk), .RST_N(rst_n), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FIRST_DECIMATOR_I(d1_i),
        .FIRST_DECIMATOR_Q(d1_q), .FIRST_DECIMATOR_VALID(d1_v), .THIRD_DECIMATOR_I(d3_i), .THIRD_DECIMATOR_Q(d3_q), .THIRD_DECIMATOR_VALID(d3_v),
        .ADC_RESET_EVT(rst_evt), .ADC_OVERLOAD_EVT(ovl_evt), .OUT_SAMPLE_STROBE(strobe), .VGA_DAC_CODE(vga),
        .FAST_ACQUIRE(fast), .OUT_I(o_i), .OUT_Q(o_q), .OUT_VALID(o_v), .FRAME_OVL_CNT(f_ovl),
        .FRAME_RST_CNT(f_rst), .FRAME_GAIN_MSB(f_gain));
    agc_far_end_model i_far (.clk(clk), .rst_n(rst_n), .dac_code(vga), .fast_acquire(fast), .out_i(o_i),
        .out_q(o_q), .out_valid(o_v), .cap_i(cap_i), .cap_q(cap_q), .cap_cnt(cap_cnt), .gcp_level(gain_control_pin));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict, reached from the main sequence and from the watchdog
    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Classic single cycle; held until ack is sampled, wait has no bound
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int c;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (ack !== 1'b1);
        q = rdat;
        if (ack !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: ack got %h expected %h", $time, ack, 1'b1);
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, rd);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0, rd);
        check(rd & m, e);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #(40000 * 20);
        n_errors++;
        close_out();
    end
    // Gain code may only move on loop ticks, sixty clocks apart
    always @(posedge clk) begin
        gap = gap + 1;
        if (watch && vga !== vga_prev) begin
            if (seen) check(32'(gap % 60), 32'h0);
            seen = 1'b1;
            gap = 0;
        end
        vga_prev = vga;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {cyc, stb, we, d1_v, d3_v, rst_evt, ovl_evt, strobe, watch, seen} = '0;
        ce = 1'b1;
        rst_n = 1'b0; sel = 4'hf; adr = 8'h00; wdat = 32'h0; vga_prev = 8'h00;
        d1_i = 24'sh7fffff; d1_q = 24'sh7fffff; d3_i = 24'sh123456; d3_q = -24'sh012346;
        n_errors = 0; tests_run = 0; gap = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc(agc_pkg::REG_CTRL, 32'hffffffff, 32'h0);
        rdc(agc_pkg::REG_STATUS, 32'hffff, 32'h0000);
        rdc(8'h10, 32'hffffffff, 32'h0);
        // Manual path ignores a large input; fast acquire reaches the DAC node
        wr(agc_pkg::REG_MANUAL, 32'hc000);
        wr(agc_pkg::REG_CTRL, 32'h8);
        d1_v <= 1'b1;
        repeat (200) @(posedge clk);
        rdc(agc_pkg::REG_STATUS, 32'hffff, 32'hc000);
        check(vga, 8'h80);
        check(fast, 1'b1);
        check(gain_control_pin, 16'h8000);
        // Digital gain shift per attenuation band, and unity when disabled
        for (int i = 0; i < 5; i++) begin
            wr(agc_pkg::REG_MANUAL, man_t[i]);
            wr(agc_pkg::REG_CTRL, (i < 4) ? 32'h80 : 32'h0);
            repeat (3) @(posedge clk);
            k = cap_cnt;
            d3_v <= 1'b1;
            @(posedge clk);
            d3_v <= 1'b0;
            for (n = 0; n < 10 && cap_cnt == k; n++) @(posedge clk);
            t_i = 24'(d3_i <<< sh_t[i]);
            t_q = 24'(d3_q <<< sh_t[i]);
            check(cap_i, t_i[23:8]);
            check(cap_q, t_q[23:8]);
        end
        // Frame counts over one sample period, then gated off
        wr(agc_pkg::REG_MANUAL, 32'hc000);
        wr(agc_pkg::REG_CTRL, 32'h10000);
        for (int i = 0; i < 5; i++) begin
            ovl_evt <= 1'b1;
            rst_evt <= (i < 3);
            @(posedge clk);
            ovl_evt <= 1'b0;
            rst_evt <= 1'b0;
            @(posedge clk);
        end
        strobe <= 1'b1;
        @(posedge clk);
        strobe <= 1'b0;
        repeat (2) @(posedge clk);
        check({f_gain, f_rst, f_ovl}, 24'hc00305);
        rdc(agc_pkg::REG_COUNTS, 32'hffff, 32'h0305);
        wr(agc_pkg::REG_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        check({f_gain, f_rst, f_ovl}, 24'h0);
        // One reset event adds a weight that doubles per code
        d1_v <= 1'b0;
        // Let the envelope fall under the reference so only resets move the gain
        repeat (300) @(posedge clk);
        for (int w = 0; w < 8; w++) begin
            wr(agc_pkg::REG_MANUAL, 32'h8000);
            wr(agc_pkg::REG_CTRL, 32'h0);
            wr(agc_pkg::REG_CTRL, 32'(w << 4) | 32'h1);
            wb(1'b0, agc_pkg::REG_STATUS, 32'h0, a0);
            rst_evt <= 1'b1;
            @(posedge clk);
            rst_evt <= 1'b0;
            repeat (130) @(posedge clk);
            wb(1'b0, agc_pkg::REG_STATUS, 32'h0, rd);
            check(32'(rd[15:0] - a0[15:0]), 32'h1 << w);
        end
        // Continuous resets at top weight ramp to the ceiling and stop there
        watch = 1'b1;
        rst_evt <= 1'b1;
        repeat (1500) @(posedge clk);
        rst_evt <= 1'b0;
        watch = 1'b0;
        rdc(agc_pkg::REG_STATUS, 32'hffff, 32'hffff);
        check(vga, 8'hff);
        // Large input: attenuation rises, faster for the higher attack code
        d1_v <= 1'b1;
        for (int a = 0; a < 16; a += 15) begin
            wr(agc_pkg::REG_MANUAL, 32'h8000);
            wr(agc_pkg::REG_CTRL, 32'h0);
            wr(agc_pkg::REG_CTRL, 32'(a << 12) | 32'h1);
            repeat (1200) @(posedge clk);
            wb(1'b0, agc_pkg::REG_STATUS, 32'h0, rd);
            if (a == 0) inc0 = rd[15:0] - 16'h8000;
        end
        check(32'(rd[15:0] - 16'h8000 > inc0), 32'h1);
        // Input removed: attenuation falls back
        a0 = rd;
        d1_i <= 24'sh0;
        d1_q <= 24'sh0;
        repeat (600) @(posedge clk);
        // Clock enable low freezes the loop while the gain code is still falling
        ce <= 1'b0;
        @(posedge clk);
        k = vga;
        repeat (200) @(posedge clk);
        check(vga, k);
        ce <= 1'b1;
        repeat (600) @(posedge clk);
        wb(1'b0, agc_pkg::REG_STATUS, 32'h0, rd);
        check(32'(rd[15:0] < a0[15:0]), 32'h1);
        close_out();
    end
endmodule // tb
